// File: design/adc_result_defines.svh
// Constants for the converter result word, word rates, gain calibration and clock limits
`ifndef ADC_RESULT_DEFINES_SVH
`define ADC_RESULT_DEFINES_SVH

// Word rate select codes, slowest to fastest
`define WR_CODE_1P88        3'h0
`define WR_CODE_3P76        3'h1
`define WR_CODE_7P51        3'h2
`define WR_CODE_15P0        3'h3
`define WR_CODE_30P0        3'h4
`define WR_CODE_61P6        3'h5
`define WR_CODE_84P5        3'h6
`define WR_CODE_101P1       3'h7
`define WR_RESET            `WR_CODE_15P0

// Master clock edges per result word, for a 32.768 kHz master clock
`define RATE_COUNT_1P88     16'h4416
`define RATE_COUNT_3P76     16'h220b
`define RATE_COUNT_7P51     16'h110b
`define RATE_COUNT_15P0     16'h0889
`define RATE_COUNT_30P0     16'h0444
`define RATE_COUNT_61P6     16'h0214
`define RATE_COUNT_84P5     16'h0184
`define RATE_COUNT_101P1    16'h0144

// Result word layout
`define WORD_BITS           24
`define MARKER_NIBBLE       4'he
`define UNI_MAX             16'hffff
`define UNI_MIN             16'h0000
`define BIP_MAX             16'h7fff
`define BIP_MIN             16'h8000

// Gain calibration register
`define GAIN_RESET          24'h400000
`define GAIN_MAX            24'hffffff

// Clock limits in Hz
`define SYS_CLOCK_HZ        25000000
`define MASTER_CLOCK_MAX_HZ 100000

`endif

// File: design/adc_result_pkg.sv
// Types shared by the converter result and power mode logic
`default_nettype none
package adc_result_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_SLEEP
  } power_mode_t;

  // Three result bytes, most significant bit first on the wire
  typedef struct packed {
    logic [15:0] data;
    logic [3:0]  marker;
    logic        channel_indicator_high;
    logic        channel_indicator_low;
    logic        oscillation_flag;
    logic        overrange_flag;
  } result_word_t;

  // Sample presented by the modulator model
  typedef struct packed {
    logic signed [17:0] value;
    logic [1:0]         channel;
  } modulator_sample_t;

endpackage
`default_nettype wire

// File: design/result_buffer.sv
// Two-entry valid/ready buffer between conversion and serial output
`default_nettype none
module result_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("result_buffer: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (PW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end

endmodule
`default_nettype wire

// File: design/adc_result_core.sv
// Result word, word rate, power mode and serial output of the converter
`include "adc_result_defines.svh"
`default_nettype none
module adc_result_core
  import adc_result_pkg::*;
#(
  parameter int unsigned RATE_SHIFT = 0
) (
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  // Master clock from crystal input or external source
  input  wire logic              i_crystal_input,
  // Channel setup and configuration bits
  input  wire logic [1:0]        i_latch_setup_bits,
  input  wire logic [2:0]        i_word_rate_select,
  input  wire logic              i_word_rate_write,
  input  wire logic              i_unipolar,
  input  wire logic              i_power_save_select,
  input  wire logic              i_power_save_run_bit,
  // Modulator side
  input  wire modulator_sample_t i_sample,
  input  wire logic              i_oscillation_detect,
  // Gain calibration result
  input  wire logic              i_gain_cal_load,
  input  wire logic [24:0]       i_gain_cal_value,
  // Serial port
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  output logic                   o_sdo,
  output logic                   o_sdo_oe_n,
  // Outputs
  output logic [1:0]             o_latch_outputs,
  output logic [2:0]             o_word_rate,
  output power_mode_t            o_power_mode,
  output logic                   o_filter_active,
  output logic                   o_oscillator_enable,
  output logic                   o_bias_enable,
  output logic [23:0]            o_gain_cal,
  output logic                   o_conversion_done,
  output logic                   o_conversion_stalled
);

  // Sampling at the system clock must resolve master clock edges
  initial begin
    if (`SYS_CLOCK_HZ < 4 * `MASTER_CLOCK_MAX_HZ) begin
      $error("adc_result_core: system clock too slow for master clock");
    end
    if (RATE_SHIFT > 8) begin
      $error("adc_result_core: RATE_SHIFT above 8 is not supported");
    end
  end

  // ------------------------------------------------------------------
  // Synchronisers for pins from outside the clock domain
  // ------------------------------------------------------------------
  logic mclk_meta_reg;
  logic mclk_sync_reg;
  logic mclk_prev_reg;
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_prev_reg;
  logic cs_meta_reg;
  logic cs_sync_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mclk_meta_reg <= 1'b0;
      mclk_sync_reg <= 1'b0;
      mclk_prev_reg <= 1'b0;
    end else begin
      mclk_meta_reg <= i_crystal_input;
      mclk_sync_reg <= mclk_meta_reg;
      mclk_prev_reg <= mclk_sync_reg;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
    end else begin
      sclk_meta_reg <= i_sclk;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      cs_meta_reg   <= i_cs_n;
      cs_sync_reg   <= cs_meta_reg;
    end
  end

  logic sclk_fall;
  logic sclk_rise;

  assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg;
  assign sclk_rise = ~sclk_prev_reg & sclk_sync_reg;

  // ------------------------------------------------------------------
  // Latch outputs and configuration
  // ------------------------------------------------------------------
  logic [1:0] latch_reg;
  logic [2:0] word_rate_reg;
  logic       unipolar_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      latch_reg <= 2'h0;
    end else begin
      latch_reg <= i_latch_setup_bits;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      word_rate_reg <= `WR_RESET;
    end else if (i_word_rate_write) begin
      word_rate_reg <= i_word_rate_select;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      unipolar_reg <= 1'b0;
    end else begin
      unipolar_reg <= i_unipolar;
    end
  end

  assign o_latch_outputs = latch_reg;
  assign o_word_rate     = word_rate_reg;

  // ------------------------------------------------------------------
  // Power modes
  // ------------------------------------------------------------------
  power_mode_t mode_reg;
  power_mode_t mode_next;

  always_comb begin
    if (!i_power_save_run_bit) begin
      mode_next = MODE_NORMAL;
    end else if (i_power_save_select) begin
      mode_next = MODE_SLEEP;
    end else begin
      mode_next = MODE_STANDBY;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mode_reg <= MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  logic filter_active;
  logic oscillator_on;

  always_comb begin
    filter_active = 1'b0;
    oscillator_on = 1'b1;
    case (mode_reg)
      MODE_NORMAL: begin
        filter_active = 1'b1;
      end
      MODE_STANDBY: begin
        filter_active = 1'b0;
      end
      MODE_SLEEP: begin
        oscillator_on = 1'b0;
      end
      default: begin
        filter_active = 1'b0;
      end
    endcase
  end

  assign o_power_mode        = mode_reg;
  assign o_filter_active     = filter_active;
  assign o_oscillator_enable = oscillator_on;
  assign o_bias_enable       = oscillator_on;

  // ------------------------------------------------------------------
  // Word rate timing, counted in master clock edges
  // ------------------------------------------------------------------
  function automatic logic [15:0] rate_count(input logic [2:0] code);
    logic [15:0] count;
    count = `RATE_COUNT_15P0;
    case (code)
      `WR_CODE_1P88:  count = `RATE_COUNT_1P88;
      `WR_CODE_3P76:  count = `RATE_COUNT_3P76;
      `WR_CODE_7P51:  count = `RATE_COUNT_7P51;
      `WR_CODE_15P0:  count = `RATE_COUNT_15P0;
      `WR_CODE_30P0:  count = `RATE_COUNT_30P0;
      `WR_CODE_61P6:  count = `RATE_COUNT_61P6;
      `WR_CODE_84P5:  count = `RATE_COUNT_84P5;
      `WR_CODE_101P1: count = `RATE_COUNT_101P1;
      default:        count = `RATE_COUNT_15P0;
    endcase
    return count;
  endfunction

  logic [15:0] period;
  logic [15:0] phase_reg;
  logic        mclk_edge;
  logic        restart;
  logic        phase_end;

  assign period = (rate_count(word_rate_reg) >> RATE_SHIFT) | 16'h0001;
  // In sleep the oscillator is off, so no master clock edges count
  assign mclk_edge = mclk_sync_reg & ~mclk_prev_reg & oscillator_on;
  // A new setting or a wake-up restarts the conversion so the next
  // result is fully settled on the new setting
  assign restart   = i_word_rate_write | ~filter_active
                   | (unipolar_reg != i_unipolar);
  // A restart cuts the running conversion, so it yields no word
  assign phase_end = mclk_edge & ~restart
                   & (phase_reg == period - 16'h0001);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      phase_reg <= 16'h0000;
    end else if (restart) begin
      phase_reg <= 16'h0000;
    end else if (phase_end) begin
      phase_reg <= 16'h0000;
    end else if (mclk_edge) begin
      phase_reg <= phase_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  logic osc_flag_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      osc_flag_reg <= 1'b0;
    end else begin
      osc_flag_reg <= i_oscillation_detect;
    end
  end

  // ------------------------------------------------------------------
  // Coding, saturation and word assembly
  // ------------------------------------------------------------------
  logic [15:0]  code_value;
  logic         overrange;
  result_word_t word_next;

  always_comb begin
    overrange  = 1'b0;
    code_value = i_sample.value[15:0];
    if (unipolar_reg) begin
      if (i_sample.value < 18'sd0) begin
        code_value = `UNI_MIN;
        overrange  = 1'b1;
      end else if (i_sample.value > 18'sd65535) begin
        code_value = `UNI_MAX;
        overrange  = 1'b1;
      end else begin
        code_value = i_sample.value[15:0];
      end
    end else begin
      if (i_sample.value < -18'sd32768) begin
        code_value = `BIP_MIN;
        overrange  = 1'b1;
      end else if (i_sample.value > 18'sd32767) begin
        code_value = `BIP_MAX;
        overrange  = 1'b1;
      end else begin
        code_value = i_sample.value[15:0];
      end
    end
  end

  always_comb begin
    word_next.data                   = code_value;
    word_next.marker                 = `MARKER_NIBBLE;
    word_next.channel_indicator_high = i_sample.channel[1];
    word_next.channel_indicator_low  = i_sample.channel[0];
    word_next.oscillation_flag       = osc_flag_reg;
    word_next.overrange_flag         = overrange;
  end

  // ------------------------------------------------------------------
  // Pending result and buffer
  // ------------------------------------------------------------------
  result_word_t pending_reg;
  logic         pending_valid_reg;
  logic         buf_in_ready;
  logic         buf_out_valid;
  logic         buf_out_ready;
  logic [23:0]  buf_out_data;
  logic         done_reg;
  logic         stall_reg;

  // A full buffer holds the pending word; a conversion that ends then
  // is dropped and reported, so no queued word is ever overwritten
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      pending_valid_reg <= 1'b0;
    end else if (phase_end && !pending_valid_reg) begin
      pending_valid_reg <= 1'b1;
    end else if (pending_valid_reg && buf_in_ready) begin
      pending_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      pending_reg <= '0;
    end else if (phase_end && !pending_valid_reg) begin
      pending_reg <= word_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      done_reg  <= 1'b0;
      stall_reg <= 1'b0;
    end else begin
      done_reg  <= phase_end & ~pending_valid_reg;
      stall_reg <= phase_end & pending_valid_reg;
    end
  end

  assign o_conversion_done    = done_reg;
  assign o_conversion_stalled = stall_reg;

  result_buffer #(
    .WIDTH (`WORD_BITS),
    .DEPTH (2)
  ) u_buffer (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_in_valid  (pending_valid_reg),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (pending_reg),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_out_ready),
    .o_out_data  (buf_out_data)
  );

  // ------------------------------------------------------------------
  // Serial output shifter
  // ------------------------------------------------------------------
  logic [23:0] shift_reg;
  logic [4:0]  bits_left_reg;
  logic        loaded;

  assign loaded = (bits_left_reg != 5'h00);
  // A word is taken only while chip select is high, so a frame never
  // starts in the middle of a word
  assign buf_out_ready = cs_sync_reg & ~loaded;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      shift_reg     <= 24'h000000;
      bits_left_reg <= 5'h00;
    end else if (buf_out_valid && buf_out_ready) begin
      shift_reg     <= buf_out_data;
      bits_left_reg <= 5'(`WORD_BITS);
    end else if (!cs_sync_reg && loaded && sclk_fall) begin
      shift_reg     <= {shift_reg[22:0], 1'b0};
      bits_left_reg <= bits_left_reg - 5'h01;
    end
  end

  // Host samples on the rising edge; data changes on the falling edge
  logic sdo_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sdo_reg <= 1'b0;
    end else if (sclk_rise && !cs_sync_reg) begin
      sdo_reg <= sdo_reg;
    end else begin
      sdo_reg <= shift_reg[23] & loaded;
    end
  end

  assign o_sdo      = sdo_reg;
  assign o_sdo_oe_n = cs_sync_reg;

  // ------------------------------------------------------------------
  // Gain calibration register
  // ------------------------------------------------------------------
  logic [23:0] gain_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      gain_reg <= `GAIN_RESET;
    end else if (i_gain_cal_load) begin
      if (i_gain_cal_value[24]) begin
        gain_reg <= `GAIN_MAX;
      end else begin
        gain_reg <= i_gain_cal_value[23:0];
      end
    end
  end

  assign o_gain_cal = gain_reg;

endmodule
`default_nettype wire

// File: sim/host_serial_model.sv
// Behavioural host that reads result words over the three-wire port
`default_nettype none
module host_serial_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  // Bits are taken late in the high phase, once the output has settled
  task automatic read_frame(output logic [23:0] word);
    #13 o_cs_n = 1'b0;
    #160;
    for (int i = 23; i >= 0; i--) begin
      #160 o_sclk = 1'b1;
      #150 word[i] = i_sdo;
      #10 o_sclk = 1'b0;
    end
    #160 o_cs_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// File: sim/adc_result_sva.sv
// Concurrent checks on the converter control and result ports
`default_nettype none
module adc_result_sva
  import adc_result_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic [1:0]  i_latch_setup_bits,
  input wire logic [2:0]  i_word_rate_select,
  input wire logic        i_word_rate_write,
  input wire logic        i_power_save_select,
  input wire logic        i_power_save_run_bit,
  input wire logic        i_gain_cal_load,
  input wire logic [24:0] i_gain_cal_value,
  input wire logic        i_cs_n,
  input wire logic        o_sdo_oe_n,
  input wire logic [1:0]  o_latch_outputs,
  input wire logic [2:0]  o_word_rate,
  input wire power_mode_t o_power_mode,
  input wire logic        o_filter_active,
  input wire logic        o_oscillator_enable,
  input wire logic        o_bias_enable,
  input wire logic [23:0] o_gain_cal,
  input wire logic        o_conversion_done
);
  logic [23:0] gain_low;
  assign gain_low = i_gain_cal_value[23:0];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence cs_idle_s;
    i_cs_n [*4];
  endsequence
  sequence save_held_s;
    (o_power_mode != MODE_NORMAL) [*3];
  endsequence
  latch_follow_a: assert property (
    $past(i_rstn) |-> o_latch_outputs == $past(i_latch_setup_bits))
    else $error("latch outputs do not follow setup bits");
  rate_load_a: assert property (
    i_word_rate_write |=> o_word_rate == $past(i_word_rate_select))
    else $error("word rate not loaded");
  rate_hold_a: assert property (
    !i_word_rate_write |=> $stable(o_word_rate))
    else $error("word rate changed without a write");
  mode_select_a: assert property (
    $past(i_rstn) |-> o_power_mode == (!$past(i_power_save_run_bit) ?
      MODE_NORMAL : ($past(i_power_save_select) ? MODE_SLEEP : MODE_STANDBY)))
    else $error("power mode wrong");
  filter_halt_a: assert property (
    o_filter_active == (o_power_mode == MODE_NORMAL))
    else $error("filter activity wrong for mode");
  osc_sleep_a: assert property (
    (o_oscillator_enable == (o_power_mode != MODE_SLEEP)) &&
    (o_bias_enable == o_oscillator_enable))
    else $error("oscillator or bias wrong for mode");
  gain_sat_a: assert property (
    i_gain_cal_load && i_gain_cal_value[24] |=> o_gain_cal == 24'hffffff)
    else $error("gain did not saturate");
  gain_load_a: assert property (
    i_gain_cal_load && !i_gain_cal_value[24] |=> o_gain_cal == $past(gain_low))
    else $error("gain not loaded");
  sdo_release_a: assert property (
    cs_idle_s |-> o_sdo_oe_n)
    else $error("serial output driven while deselected");
  conv_halt_a: assert property (
    save_held_s |-> !o_conversion_done)
    else $error("conversion during power save");
  done_pulse_a: assert property (
    o_conversion_done |=> !o_conversion_done)
    else $error("done pulse longer than one cycle");
endmodule
bind adc_result_core adc_result_sva i_sva (
  .i_clock, .i_rstn, .i_latch_setup_bits, .i_word_rate_select,
  .i_word_rate_write, .i_power_save_select, .i_power_save_run_bit,
  .i_gain_cal_load, .i_gain_cal_value, .i_cs_n, .o_sdo_oe_n,
  .o_latch_outputs, .o_word_rate, .o_power_mode, .o_filter_active,
  .o_oscillator_enable, .o_bias_enable, .o_gain_cal, .o_conversion_done);
`default_nettype wire

// File: sim/adc_result_word_and_power_modes_tb.sv
// Testbench for the converter result word and power mode logic
`include "adc_result_defines.svh"
`default_nettype none
module adc_result_word_and_power_modes_tb;
  import adc_result_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              i_clock = 1'b0, i_rstn = 1'b0, i_crystal_input = 1'b0;
  logic [1:0]        i_latch_setup_bits = 2'h0;
  logic [2:0]        i_word_rate_select = 3'h0, xdiv = 3'h0;
  logic              i_word_rate_write = 1'b0, i_unipolar = 1'b0;
  logic              i_power_save_select = 1'b0, i_power_save_run_bit = 1'b0;
  modulator_sample_t i_sample = '0;
  logic              i_oscillation_detect = 1'b0, i_gain_cal_load = 1'b0;
  logic [24:0]       i_gain_cal_value = 25'h0;
  wire logic         i_sclk, i_cs_n, sdo_line;
  logic              o_sdo, o_sdo_oe_n, o_filter_active;
  logic              o_oscillator_enable, o_bias_enable;
  logic              o_conversion_done, o_conversion_stalled;
  logic [1:0]        o_latch_outputs;
  logic [2:0]        o_word_rate;
  power_mode_t       o_power_mode;
  logic [23:0]       o_gain_cal;
  int                errors = 0, n_checks = 0, cycles = 0;
  integer            seed = 32'h0d25;
  int                corner [8] = '{-1, 0, 65535, 65536,
                                    -32769, -32768, 32767, 32768};
  localparam int     RATE_SHIFT  = 8;
  localparam int     MCLK_CYCLES = 10;
  int                rate_count [8] = '{`RATE_COUNT_1P88, `RATE_COUNT_3P76,
                       `RATE_COUNT_7P51, `RATE_COUNT_15P0, `RATE_COUNT_30P0,
                       `RATE_COUNT_61P6, `RATE_COUNT_84P5, `RATE_COUNT_101P1};

  // Released line rests high through its pull-up
  assign sdo_line = o_sdo_oe_n ? 1'b1 : o_sdo;

  adc_result_core #(.RATE_SHIFT(RATE_SHIFT)) i_dut (
    .i_clock, .i_rstn, .i_crystal_input, .i_latch_setup_bits,
    .i_word_rate_select, .i_word_rate_write, .i_unipolar,
    .i_power_save_select, .i_power_save_run_bit, .i_sample,
    .i_oscillation_detect, .i_gain_cal_load, .i_gain_cal_value, .i_sclk,
    .i_cs_n, .o_sdo, .o_sdo_oe_n, .o_latch_outputs, .o_word_rate,
    .o_power_mode, .o_filter_active, .o_oscillator_enable, .o_bias_enable,
    .o_gain_cal, .o_conversion_done, .o_conversion_stalled);
  host_serial_model i_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n),
                            .i_sdo(sdo_line));

  always #20 i_clock = ~i_clock;
  // Master clock at one tenth of the system clock, plus the run limit
  always @(posedge i_clock) begin
    xdiv <= (xdiv == 3'h4) ? 3'h0 : xdiv + 3'h1;
    if (xdiv == 3'h4) begin
      i_crystal_input <= ~i_crystal_input;
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  // System cycles between two conversion ends for a word rate code
  function automatic int expect_period(input logic [2:0] c);
    return MCLK_CYCLES * ((rate_count[c] >> RATE_SHIFT) | 1);
  endfunction

  function automatic result_word_t expect_word(input logic signed [17:0] v,
    input logic [1:0] ch, input logic u, input logic o);
    result_word_t w;
    w = '{data: v[15:0], marker: `MARKER_NIBBLE,
          channel_indicator_high: ch[1], channel_indicator_low: ch[0],
          oscillation_flag: o, overrange_flag: 1'b1};
    if (u && v < 0) w.data = `UNI_MIN;
    else if (u && v > 65535) w.data = `UNI_MAX;
    else if (!u && v < -32768) w.data = `BIP_MIN;
    else if (!u && v > 32767) w.data = `BIP_MAX;
    else w.overrange_flag = 1'b0;
    return w;
  endfunction

  initial begin
    logic [2:0]         code;
    logic signed [17:0] v;
    logic               u, o;
    logic [1:0]         ch;
    logic [23:0]        g;
    result_word_t       got;
    int                 k;
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    settle(2);
    check("word rate", o_word_rate, `WR_RESET);
    check("mode", o_power_mode, MODE_NORMAL);
    check("filter", o_filter_active, 1'b1);
    check("gain", o_gain_cal, `GAIN_RESET);
    check("sdo enable", o_sdo_oe_n, 1'b1);
    $display("test reset done");
    repeat (8) begin
      @(posedge i_clock);
      i_latch_setup_bits <= 2'($random(seed));
      settle(1);
      check("latch", o_latch_outputs, i_latch_setup_bits);
    end
    $display("test latch done");
    for (k = 0; k < 5; k++) begin
      @(posedge i_clock);
      {i_power_save_select, i_power_save_run_bit} <= 2'(k);
      settle(4); // Stands in for the start-up wait after sleep
      check("mode", o_power_mode, k[0] ? (k[1] ? MODE_SLEEP : MODE_STANDBY)
            : MODE_NORMAL);
      check("filter", o_filter_active, !k[0]);
      check("oscillator", o_oscillator_enable, !(k[0] && k[1]));
      check("bias", o_bias_enable, !(k[0] && k[1]));
    end
    $display("test power done");
    for (k = 0; k < 6; k++) begin
      @(posedge i_clock);
      g = 24'($random(seed));
      i_gain_cal_value <= {k[0], g};
      i_gain_cal_load <= 1'b1;
      @(posedge i_clock);
      i_gain_cal_load <= 1'b0;
      settle(0);
      check("gain", o_gain_cal, k[0] ? `GAIN_MAX : g);
    end
    $display("test gain done");
    for (int r = 0; r < 16; r++) begin
      @(posedge i_clock);
      code = (r < 8) ? 3'(r) : 3'($random(seed));
      v = (r < 8) ? 18'(corner[r]) : 18'($random(seed));
      u = (r < 8) ? (r < 4) : 1'($random(seed));
      o = 1'($random(seed));
      ch = 2'($random(seed));
      i_word_rate_select <= code;
      i_word_rate_write <= 1'b1;
      i_sample <= '{value: v, channel: ch};
      i_unipolar <= u;
      i_oscillation_detect <= o;
      @(posedge i_clock);
      i_word_rate_write <= 1'b0;
      settle(0);
      check("word rate", o_word_rate, code);
      settle(4);
      // Drain shifter, both buffer entries and the pending word
      repeat (4) i_host.read_frame(got);
      k = 0;
      while ((o_conversion_done | o_conversion_stalled) !== 1'b1 && k < 1000)
      begin
        @(negedge i_clock);
        k++;
      end
      check("conversion", k < 1000, 1'b1);
      k = 0;
      do begin
        @(negedge i_clock);
        k++;
      end while ((o_conversion_done | o_conversion_stalled) !== 1'b1 &&
                 k < 1000);
      check("word period", 24'(k), 24'(expect_period(code)));
      settle(4);
      i_host.read_frame(got);
      check("result word", got, expect_word(v, ch, u, o));
      $display("test word %0d done", r);
    end
    summarize();
  end
endmodule
`default_nettype wire
